//--- mafe_pkg.sv
//==========================================
// Shared constants and types
package mafe_pkg;
    typedef logic [7:0] mafe_byte_t;

    //==========================================
    // Command bytes
    localparam mafe_byte_t CMD_RESUME = 8'h5a;   // Broadcast resume of metrology
    localparam mafe_byte_t CMD_SYNC = 8'hdb;     // Broadcast mains-cycle counter clear
    localparam mafe_byte_t CMD_CAL_BASE = 8'hd0; // Calibration write header, plus phase

    //==========================================
    // Packet lengths and counts
    localparam int unsigned N_PHASES = 3;        // Front ends on the bus
    localparam int unsigned CAL_LEN = 31;        // Bytes of a calibration write
    localparam int unsigned ACK_LEN = 2;         // Bytes of its acknowledgement
    localparam int unsigned CYC_PER_RESULT = 50; // Mains cycles per results pulse
    localparam logic [4:0] CAL_LAST = 5'h1e;     // Index of the last packet byte
    localparam logic [1:0] ACK_BYTES = 2'h2;     // Acknowledge bytes to send

    //==========================================
    // Timing
    localparam real CLK_HZ = 125.0e6;            // System clock rate
    localparam real MISS_TIME_S = 1.05;          // Silence that flags a phase missing
    localparam int unsigned MISS_CYC = $rtoi(MISS_TIME_S * CLK_HZ);
    localparam int unsigned RDY_DELAY_CYC = 16;  // Zero crossing to results pulse
    localparam int unsigned BYTE_GAP_CYC = 8;    // Host spacing between sent bytes
    localparam int unsigned TICK_CYC = 1024;     // Host periodic timer period
    localparam int unsigned ACK_TIMEOUT_CYC = 4096; // Host wait for an acknowledge

    typedef enum logic [1:0] {
        MAFE_P_IDLE = 2'b00,
        MAFE_P_MINE = 2'b01,
        MAFE_P_SKIP = 2'b10
    } mafe_parse_e;

    typedef enum logic [2:0] {
        MAFE_H_IDLE = 3'b000,
        MAFE_H_CAL_TX = 3'b001,
        MAFE_H_ACK_WAIT = 3'b010,
        MAFE_H_RESUME = 3'b011,
        MAFE_H_SYNC = 3'b100
    } mafe_host_e;
endpackage

//--- mafe_link_if.sv
`timescale 1ns/100ps
//==========================================
// Host to front ends link, byte level
interface mafe_link_if #(
    parameter int unsigned N_PH = 3
);
    logic cmd_valid;                     // Host broadcast byte strobe
    mafe_pkg::mafe_byte_t cmd_byte;      // Host broadcast byte
    wire [N_PH-1:0] rsp_valid;           // Per front end response strobe
    wire [N_PH*8-1:0] rsp_byte;          // Per front end response byte
    wire [N_PH-1:0] results_ready_pulse; // Per front end results pulse

    modport host(
        output cmd_valid, cmd_byte,
        input rsp_valid, rsp_byte, results_ready_pulse
    );
    modport dev(
        input cmd_valid, cmd_byte,
        output rsp_valid, rsp_byte, results_ready_pulse
    );
endinterface

//--- mafe_frontend.sv
`timescale 1ns/100ps
module mafe_frontend #(
    parameter int unsigned PHASE = 1,
    parameter int unsigned N_PH = mafe_pkg::N_PHASES,
    parameter int unsigned RDY_DELAY = mafe_pkg::RDY_DELAY_CYC,
    parameter int unsigned CYC_PER = mafe_pkg::CYC_PER_RESULT
) (
    input wire logic clk,                   // System clock
    input wire logic rst,                   // Asynchronous reset, active high
    mafe_link_if.dev link,                  // Link to the host
    input wire logic zc_pulse,              // Leading zero crossing, one cycle
    output logic metro_en,                  // Metrology calculations running
    output logic cal_byte_valid,            // Calibration factor byte strobe
    output mafe_pkg::mafe_byte_t cal_byte,  // Calibration factor byte
    output logic [4:0] cal_offset,          // Byte offset within the packet
    output logic cal_apply,                 // New factors complete, apply now
    output logic [5:0] mains_count          // Mains cycles since last pulse
);
    import mafe_pkg::*;

    //==========================================
    // Elaboration checks
    // Phase index must name one front end
    if (PHASE < 1 || PHASE > N_PH) begin : g_bad_phase
        $error("PHASE out of range");
    end
    // Period must fit the six-bit cycle counter
    if (CYC_PER < 2 || CYC_PER > 63) begin : g_bad_cyc
        $error("CYC_PER out of range");
    end
    // Delay must fit the eight-bit timer
    if (RDY_DELAY < 1 || RDY_DELAY > 255) begin : g_bad_dly
        $error("RDY_DELAY out of range");
    end

    //==========================================
    // Derived constants
    localparam mafe_byte_t MY_HDR = mafe_byte_t'(CMD_CAL_BASE + PHASE);
    localparam mafe_byte_t LAST_HDR = mafe_byte_t'(CMD_CAL_BASE + N_PH);
    localparam logic [5:0] CYC_LAST = 6'(CYC_PER - 1);
    localparam logic [7:0] DLY_LOAD = 8'(RDY_DELAY);

    //==========================================
    // State and decode signals
    // Packet parser state and byte index
    mafe_parse_e state_q;
    logic [4:0] cnt_q;
    // Metrology enable and acknowledge
    logic metro_en_q;
    logic [1:0] tx_left_q;
    logic rsp_valid_q;
    // Mains cycles and results delay
    logic [5:0] cyc_q;
    logic [7:0] dly_q;
    logic rdy_q;
    // Combinational decode
    logic is_hdr;
    logic is_mine;
    logic last_byte;
    logic at_start;
    logic in_mine;
    logic resume_hit;
    logic sync_hit;

    //==========================================
    // Command decode
    assign is_hdr = link.cmd_byte > CMD_CAL_BASE && link.cmd_byte <= LAST_HDR;
    assign is_mine = link.cmd_byte == MY_HDR;
    assign last_byte = cnt_q == CAL_LAST;
    // Byte taken at packet start, or inside own packet
    assign at_start = link.cmd_valid && state_q == MAFE_P_IDLE;
    assign in_mine = link.cmd_valid && state_q == MAFE_P_MINE;
    // Broadcasts only count at packet start, never as data
    assign resume_hit = at_start && link.cmd_byte == CMD_RESUME;
    assign sync_hit = at_start && link.cmd_byte == CMD_SYNC;

    //==========================================
    // Packet parser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= MAFE_P_IDLE;
            cnt_q <= 5'h00;
        end else if (link.cmd_valid) begin
            case (state_q)
                MAFE_P_IDLE: begin
                    cnt_q <= 5'h01;
                    if (is_mine) begin
                        state_q <= MAFE_P_MINE;
                    end else if (is_hdr) begin
                        state_q <= MAFE_P_SKIP;
                    end
                end
                MAFE_P_MINE, MAFE_P_SKIP: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (last_byte) begin
                        state_q <= MAFE_P_IDLE;
                    end
                end
                default: begin
                    state_q <= MAFE_P_IDLE;
                end
            endcase
        end
    end

    //==========================================
    // Metrology enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            metro_en_q <= 1'b1;
        end else if (at_start) begin
            if (is_mine) begin
                metro_en_q <= 1'b0;
            end else if (resume_hit) begin
                metro_en_q <= 1'b1;
            end
        end
    end
    assign metro_en = metro_en_q;

    //==========================================
    // Factor byte outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_byte_valid <= 1'b0;
            cal_byte <= 8'h00;
            cal_offset <= 5'h00;
            cal_apply <= 1'b0;
        end else begin
            cal_byte_valid <= in_mine;
            cal_apply <= in_mine && last_byte;
            if (in_mine) begin
                cal_byte <= link.cmd_byte;
                cal_offset <= cnt_q;
            end
        end
    end

    //==========================================
    // Acknowledge transmitter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_left_q <= 2'h0;
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= tx_left_q != 2'h0;
            if (in_mine && last_byte) begin
                tx_left_q <= ACK_BYTES;
            end else if (tx_left_q != 2'h0) begin
                tx_left_q <= tx_left_q - 2'h1;
            end
        end
    end
    assign link.rsp_valid[PHASE-1] = rsp_valid_q;
    // Acknowledge byte echoes own header
    assign link.rsp_byte[(PHASE-1)*8 +: 8] = MY_HDR;

    //==========================================
    // Mains-cycle counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_q <= 6'h00;
        end else if (sync_hit) begin
            cyc_q <= 6'h00;
        end else if (zc_pulse) begin
            cyc_q <= (cyc_q == CYC_LAST) ? 6'h00 : cyc_q + 6'h01;
        end
    end
    assign mains_count = cyc_q;

    //==========================================
    // Results pulse delay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_q <= 8'h00;
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= dly_q == 8'h01 && metro_en_q;
            if (zc_pulse && cyc_q == CYC_LAST) begin
                dly_q <= DLY_LOAD;
            end else if (dly_q != 8'h00) begin
                dly_q <= dly_q - 8'h01;
            end
        end
    end
    // Results pulse to the host
    assign link.results_ready_pulse[PHASE-1] = rdy_q;
endmodule

//--- mafe_host.sv
`timescale 1ns/100ps
//==========================================
// Host end: calibration delivery, resync
module mafe_host #(
    parameter int unsigned N_PH = mafe_pkg::N_PHASES,
    parameter int unsigned MISS = mafe_pkg::MISS_CYC,
    parameter int unsigned GAP = mafe_pkg::BYTE_GAP_CYC,
    parameter int unsigned TICK = mafe_pkg::TICK_CYC,
    parameter int unsigned ACK_TO = mafe_pkg::ACK_TIMEOUT_CYC
) (
    input wire logic clk,                   // System clock
    input wire logic rst,                   // Asynchronous reset, active high
    mafe_link_if.host link,                 // Link to the front ends
    input wire logic cal_start,             // Deliver factors, one cycle
    input wire logic [1:0] cal_phase,       // Target phase, 1 to N_PH
    input mafe_pkg::mafe_byte_t fac_byte,   // Packet byte at fac_idx
    output logic [4:0] fac_idx,             // Packet byte wanted next
    output logic cal_busy,                  // Interrupts held off
    output logic cal_done,                  // Calibration reported done
    output logic cal_fail,                  // Acknowledge timed out
    input wire logic [N_PH-1:0] vrms_low,   // Voltage below interruption level
    output logic [N_PH-1:0] phase_missing,  // Phase flagged missing
    output logic sync_sent                  // Sync command issued
);
    import mafe_pkg::*;

    if (N_PH < 1 || N_PH > 3 || GAP < 1 || TICK < 1 || MISS < 2 || ACK_TO < 1) begin : g_bad
        $error("mafe_host parameter out of range");
    end
    // Pacing, tick and timeout counters are sixteen bits wide
    if (GAP > 65536 || TICK > 65536 || ACK_TO > 65535) begin : g_bad_cnt
        $error("mafe_host counter parameter too large");
    end

    localparam int MW = $clog2(MISS + 1);
    localparam logic [MW-1:0] MISS_W = MW'(MISS);
    localparam logic [15:0] GAP_W = 16'(GAP - 1);
    localparam logic [15:0] TICK_W = 16'(TICK - 1);
    localparam logic [15:0] TO_W = 16'(ACK_TO);

    mafe_host_e state_q;
    logic [1:0] ph_q;
    logic [15:0] gap_q;
    logic [15:0] tick_q;
    logic [15:0] to_q;
    logic ack_cnt_q;
    logic sync_pend_q;
    logic any_miss_q;
    logic send_en;
    logic tick;
    logic ack_hit;
    logic [N_PH-1:0] miss_now;
    mafe_byte_t hdr;

    //==========================================
    // Byte pacing and periodic tick
    assign send_en = gap_q == 16'h0000;
    assign tick = tick_q == 16'h0000;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q <= 16'h0000;
            tick_q <= 16'h0000;
        end else begin
            gap_q <= send_en ? GAP_W : gap_q - 16'h0001;
            tick_q <= tick ? TICK_W : tick_q - 16'h0001;
        end
    end

    //==========================================
    // Missing phase detection
    for (genvar i = 0; i < N_PH; i++) begin : g_ph
        logic [MW-1:0] tmr_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                tmr_q <= '0;
            end else if (link.results_ready_pulse[i]) begin
                tmr_q <= '0;
            end else if (tmr_q != MISS_W) begin
                tmr_q <= tmr_q + 1'b1;
            end
        end
        assign miss_now[i] = vrms_low[i] || tmr_q == MISS_W;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_missing <= '0;
            any_miss_q <= 1'b0;
        end else begin
            phase_missing <= miss_now;
            any_miss_q <= |miss_now;
        end
    end

    // Pending sync, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_pend_q <= 1'b0;
        end else if (any_miss_q && !(|miss_now)) begin
            sync_pend_q <= 1'b1;
        end else if (state_q == MAFE_H_SYNC && send_en) begin
            sync_pend_q <= 1'b0;
        end
    end

    //==========================================
    // Command sequencer
    assign hdr = CMD_CAL_BASE + {6'h00, ph_q};
    assign ack_hit = link.rsp_valid[ph_q-2'h1] && link.rsp_byte[(ph_q-2'h1)*8 +: 8] == hdr;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= MAFE_H_IDLE;
            ph_q <= 2'h1;
            fac_idx <= 5'h00;
            to_q <= 16'h0000;
            ack_cnt_q <= 1'b0;
            link.cmd_valid <= 1'b0;
            link.cmd_byte <= 8'h00;
            cal_done <= 1'b0;
            cal_fail <= 1'b0;
            sync_sent <= 1'b0;
        end else begin
            link.cmd_valid <= 1'b0;
            cal_done <= 1'b0;
            cal_fail <= 1'b0;
            sync_sent <= 1'b0;
            case (state_q)
                MAFE_H_IDLE: begin
                    fac_idx <= 5'h00;
                    if (cal_start && cal_phase != 2'h0 && cal_phase <= 2'(N_PH)) begin
                        ph_q <= cal_phase;
                        state_q <= MAFE_H_CAL_TX;
                    end else if (tick && sync_pend_q) begin
                        state_q <= MAFE_H_SYNC;
                    end
                end
                MAFE_H_CAL_TX: begin
                    if (send_en) begin
                        link.cmd_valid <= 1'b1;
                        link.cmd_byte <= (fac_idx == 5'h00) ? hdr : fac_byte;
                        fac_idx <= fac_idx + 5'h01;
                        ack_cnt_q <= 1'b0;
                        to_q <= TO_W;
                        if (fac_idx == CAL_LAST) begin
                            state_q <= MAFE_H_ACK_WAIT;
                        end
                    end
                end
                MAFE_H_ACK_WAIT: begin
                    to_q <= to_q - 16'h0001;
                    if (ack_hit) begin
                        ack_cnt_q <= 1'b1;
                        if (ack_cnt_q) begin
                            state_q <= MAFE_H_RESUME;
                        end
                    end else if (to_q == 16'h0000) begin
                        cal_fail <= 1'b1;
                        state_q <= MAFE_H_IDLE;
                    end
                end
                MAFE_H_RESUME: begin
                    if (send_en) begin
                        link.cmd_valid <= 1'b1;
                        link.cmd_byte <= CMD_RESUME;
                        cal_done <= 1'b1;
                        state_q <= MAFE_H_IDLE;
                    end
                end
                MAFE_H_SYNC: begin
                    if (send_en) begin
                        link.cmd_valid <= 1'b1;
                        link.cmd_byte <= CMD_SYNC;
                        sync_sent <= 1'b1;
                        state_q <= MAFE_H_IDLE;
                    end
                end
                default: begin
                    state_q <= MAFE_H_IDLE;
                end
            endcase
        end
    end

    assign cal_busy = state_q == MAFE_H_CAL_TX || state_q == MAFE_H_ACK_WAIT || state_q == MAFE_H_RESUME;
endmodule

//--- mafe_sync_checker.sv
`timescale 1ns/100ps
//==========================================
// Link checker
module mafe_sync_checker #(
    parameter int unsigned N_PH = 3
) (
    input wire logic clk, // System clock
    input wire logic rst, // Reset, active high
    input wire logic cmd_valid, // Host byte strobe
    input mafe_pkg::mafe_byte_t cmd_byte, // Host byte
    input wire logic [N_PH-1:0] rsp_valid, // Response strobes
    input wire logic [N_PH*8-1:0] rsp_byte, // Response bytes
    input wire logic [N_PH-1:0] results_ready_pulse // Results pulses
);
    import mafe_pkg::*;
    logic [1:0] acks_q;
    logic is_res;
    logic is_sync;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Broadcast command decode
    assign is_res = cmd_valid && cmd_byte == CMD_RESUME;
    assign is_sync = cmd_valid && cmd_byte == CMD_SYNC;
    // Acknowledge strobes since last resume
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acks_q <= 2'h0;
        end else if (is_res) begin
            acks_q <= 2'h0;
        end else if (|rsp_valid && acks_q != 2'h3) begin
            acks_q <= acks_q + 2'h1;
        end
    end
    chk_resume_silent: assert property (is_res |=> (rsp_valid == '0) [*4])
        else $error("reply after resume");
    chk_sync_silent: assert property (is_sync |=> (rsp_valid == '0) [*4])
        else $error("reply after sync");
    chk_resume_after_ack: assert property (is_res |-> acks_q == 2'h2)
        else $error("resume without full acknowledge");
    chk_ack_pair: assert property ($rose(|rsp_valid) |=> (|rsp_valid) ##1 !(|rsp_valid))
        else $error("acknowledge not two bytes");
    chk_ack_timing: assert property ($rose(|rsp_valid) |-> $past(cmd_valid, 2))
        else $error("acknowledge not after last byte");
    chk_one_responder: assert property (|rsp_valid |-> $onehot(rsp_valid))
        else $error("several front ends answer");
    chk_pulse_single: assert property (|results_ready_pulse |=> (results_ready_pulse & $past(results_ready_pulse)) == '0)
        else $error("results pulse longer than one cycle");
    for (genvar g = 0; g < N_PH; g++) begin : g_ph
        chk_ack_byte: assert property (rsp_valid[g] |-> rsp_byte[g*8 +: 8] == CMD_CAL_BASE + 8'(g + 1))
            else $error("acknowledge byte wrong");
    end
endmodule

//--- metrology_afe_command_sync_test.sv
`timescale 1ns/100ps
//==========================================
// Host and three front ends
module metrology_afe_command_sync_test;
    import mafe_pkg::*;
    localparam int RDY = 3;
    localparam int CYC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cal_start = 1'b0;
    logic [1:0] cal_phase = 2'h0;
    logic [2:0] vrms_low = 3'h0;
    logic [2:0] zc = 3'h0;
    mafe_byte_t fac_byte;
    logic [4:0] fac_idx;
    logic cal_busy, cal_done, cal_fail, sync_sent;
    logic [2:0] phase_missing, metro_en, cb_valid, cal_apply;
    logic [2:0] ap_metro = 3'h0;
    mafe_byte_t cb [3];
    logic [4:0] cb_off [3];
    logic [5:0] mains_count [3];
    int miscompares = 0, n_tests = 0, cyc = 0, last_zc = 0, n_done = 0, n_sync = 0, n_bad = 0, n_cb = 0;
    int n_fail = 0;
    int n_rdy [3] = '{default: 0};
    int last_rdy [3] = '{default: 0};
    mafe_link_if #(.N_PH(3)) link ();
    mafe_host #(.MISS(600), .GAP(2), .TICK(16)) i_mafe_host (.clk(clk), .rst(rst), .link(link),
        .cal_start(cal_start), .cal_phase(cal_phase), .fac_byte(fac_byte), .fac_idx(fac_idx), .cal_busy(cal_busy),
        .cal_done(cal_done), .cal_fail(cal_fail), .vrms_low(vrms_low), .phase_missing(phase_missing),
        .sync_sent(sync_sent));
    for (genvar g = 0; g < 3; g++) begin : g_fe
        mafe_frontend #(.PHASE(g + 1), .RDY_DELAY(RDY), .CYC_PER(CYC)) i_mafe_frontend (.clk(clk), .rst(rst),
            .link(link), .zc_pulse(zc[g]), .metro_en(metro_en[g]), .cal_byte_valid(cb_valid[g]), .cal_byte(cb[g]),
            .cal_offset(cb_off[g]), .cal_apply(cal_apply[g]), .mains_count(mains_count[g]));
    end
    mafe_sync_checker #(.N_PH(3)) i_mafe_sync_checker (.clk(clk), .rst(rst), .cmd_valid(link.cmd_valid),
        .cmd_byte(link.cmd_byte), .rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte),
        .results_ready_pulse(link.results_ready_pulse));
    // Factor byte equals its offset
    assign fac_byte = {3'h0, fac_idx};
    // Clock
    always #4 clk = ~clk;
    // Event counters and watchdog
    always @(posedge clk) begin
        cyc++;
        if (zc != 3'h0) last_zc = cyc;
        if (cal_done) n_done++;
        if (sync_sent) n_sync++;
        if (cal_fail) n_fail++;
        for (int p = 0; p < 3; p++) begin
            if (link.results_ready_pulse[p]) begin
                n_rdy[p]++;
                last_rdy[p] = cyc;
            end
            if (cb_valid[p]) n_cb++;
            if (cb_valid[p] && cb[p] !== {3'h0, cb_off[p]}) n_bad++;
            if (cal_apply[p]) ap_metro = metro_en;
        end
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic zc_send(logic [2:0] m, int n);
        repeat (n) begin
            @(posedge clk);
            zc <= m;
            @(posedge clk);
            zc <= 3'h0;
            tick(2);
        end
    endtask
    //==========================================
    // Scenarios
    task automatic t_results();
        zc_send(3'h7, CYC);
        tick(RDY + 4);
        for (int p = 0; p < 3; p++) begin
            chk("pulse count", n_rdy[p], 1);
            chk("pulse delay", last_rdy[p] - last_zc, RDY + 1);
        end
    endtask
    task automatic t_cal(int p);
        int d0;
        int c0;
        d0 = n_done;
        c0 = n_cb;
        @(posedge clk);
        cal_start <= 1'b1;
        cal_phase <= p[1:0];
        @(posedge clk);
        cal_start <= 1'b0;
        tick(1);
        chk("cal_busy set", cal_busy, 1'b1);
        for (int i = 0; i < 500 && n_done == d0; i++) tick(1);
        tick(2);
        chk("cal_done", n_done - d0, 1);
        chk("factor bytes", n_cb - c0, 30);
        chk("metro at apply", ap_metro, 3'h7 ^ (3'h1 << (p - 1)));
        chk("metro resumed", metro_en, 3'h7);
        chk("cal_busy clear", cal_busy, 1'b0);
        chk("cal_fail count", n_fail, 0);
    endtask
    // Sync made pending during a calibration waits for idle
    task automatic t_busy_sync();
        int s0;
        int d0;
        s0 = n_sync;
        d0 = n_done;
        @(posedge clk);
        cal_start <= 1'b1;
        cal_phase <= 2'h1;
        @(posedge clk);
        cal_start <= 1'b0;
        vrms_low <= 3'h4;
        tick(2);
        vrms_low <= 3'h0;
        for (int i = 0; i < 500 && n_done == d0; i++) tick(1);
        chk("busy cal_done", n_done - d0, 1);
        chk("no sync while busy", n_sync - s0, 0);
        for (int i = 0; i < 100 && n_sync == s0; i++) tick(1);
        tick(1);
        chk("sync after idle", n_sync - s0, 1);
    endtask
    task automatic t_sync();
        int s0;
        for (int i = 0; i < 800 && phase_missing != 3'h7; i++) tick(1);
        chk("silence flags", phase_missing, 3'h7);
        vrms_low <= 3'h2;
        zc_send(3'h1, 2);
        zc_send(3'h7, CYC);
        tick(RDY + 4);
        s0 = n_sync;
        chk("low voltage flag", phase_missing, 3'h2);
        chk("offset count", mains_count[0], 2);
        @(posedge clk);
        vrms_low <= 3'h0;
        for (int i = 0; i < 100 && n_sync == s0; i++) tick(1);
        tick(3);
        chk("sync sent", n_sync - s0, 1);
        for (int p = 0; p < 3; p++) chk("count cleared", mains_count[p], 0);
        zc_send(3'h7, CYC);
        tick(RDY + 4);
        for (int p = 0; p < 3; p++) chk("aligned pulse", last_rdy[p] - last_zc, RDY + 1);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(2);
        rst <= 1'b0;
        tick(1);
        t_results();
        for (int p = 1; p <= 3; p++) t_cal(p);
        t_sync();
        t_busy_sync();
        chk("factor data", n_bad, 0);
        final_report();
    end
endmodule
